// file: core/opmode_ctrl.v
/*
 * Operating mode and power controller: clock source choice, halt into
 * sleep or idle, wake-up handling, power-down and timeout flags, with
 * an APB register slave.
 * Assumes the CPU pulses halt_i and clr_wdt_i for one cycle, that the
 * watchdog pulses wdt_ovf_i, and that all inputs share clock_i.
 */
// The implementer's own choices: the APB slave port and the address map.
module opmode_ctrl #(
  parameter PA_W  = 8,
  parameter INT_N = 4,
  parameter TMR_W = 5
) (
  input  wire             clock_i,
  input  wire             rst_i,
  input  wire             psel_i,
  input  wire             penable_i,
  input  wire             pwrite_i,
  input  wire [7:0]       paddr_i,
  input  wire [31:0]      pwdata_i,
  output reg  [31:0]      prdata_o,
  output reg              pready_o,
  output reg              pslverr_o,
  input  wire             halt_i,
  input  wire             clr_wdt_i,
  input  wire             wdt_ovf_i,
  input  wire [PA_W-1:0]  porta_i,
  input  wire [INT_N-1:0] int_req_i,
  input  wire [INT_N-1:0] int_en_i,
  input  wire             stack_full_i,
  output reg  [3:0]       sysclk_sel_o,
  output reg              fast_osc_en_o,
  output reg              fast_div_run_o,
  output reg              sysclk_run_o,
  output reg              timebase_run_o,
  output reg              low_clk_run_o,
  output reg              cpu_run_o,
  output reg              state_hold_o,
  output reg              wdt_clear_o,
  output reg              pc_sp_reset_o,
  output reg              int_service_o,
  output reg              wake_resume_o
);

`include "opmode_defs.vh"

  // ----------------------------------------------------------------------
  // states and wake causes
  // ----------------------------------------------------------------------
  localparam [2:0] ST_RUN   = 3'h0;
  localparam [2:0] ST_SLEEP = 3'h1;
  localparam [2:0] ST_IDLE0 = 3'h2;
  localparam [2:0] ST_IDLE1 = 3'h3;
  localparam [2:0] ST_WAKE  = 3'h4;

  localparam [1:0] WK_PORT = 2'h0;
  localparam [1:0] WK_RES  = 2'h1;
  localparam [1:0] WK_SVC  = 2'h2;
  localparam [1:0] WK_WDT  = 2'h3;

  localparam [TMR_W-1:0] HRDY_CNT = `OPM_HRDY_CYC;
  localparam [TMR_W-1:0] LRDY_CNT = `OPM_LRDY_CYC;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function sel_is_fast;
    input [3:0] sel;
    begin
      sel_is_fast = sel[3] || (sel[2:0] >= `OPM_DIV_FAST_MIN);
    end
  endfunction

  function reg_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      reg_hit = (addr == ofs);
    end
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg  [2:0]       state_reg;
  reg  [2:0]       state_next;
  reg  [1:0]       cause_reg;
  reg  [1:0]       cause_next;
  reg  [2:0]       div_reg;
  reg              fast_reg;
  reg              idle_on_halt_enable_reg;
  reg              sysidle_reg;
  reg  [PA_W-1:0]  wake_en_reg;
  reg              pdf_reg;
  reg              tof_reg;
  reg  [PA_W-1:0]  pa_prev_reg;
  reg  [INT_N-1:0] armed_reg;
  reg              resume_next;
  reg              service_next;
  reg              pcsp_next;
  reg              wake_start;
  wire [TMR_W-1:0] tmr_count;
  wire             tmr_start;
  wire             mode_fast;
  wire             hrdy;
  wire             lrdy;
  wire             halt_take;
  wire             port_wake;
  wire             int_wake;
  wire             int_svc;
  wire             wake_any;
  wire             awake_next;
  wire             osc_next;
  wire             wr_en;
  wire             acc;

  // ----------------------------------------------------------------------
  // clock selection
  // ----------------------------------------------------------------------
  assign mode_fast = sel_is_fast({fast_reg, div_reg});
  assign awake_next = (state_next != ST_SLEEP) &&
                      (state_next != ST_IDLE0);
  // fast osc runs outside SLEEP and IDLE0 while the applied or requested source needs it
  assign osc_next = awake_next &&
                    (mode_fast || sel_is_fast(sysclk_sel_o));
  assign hrdy = fast_osc_en_o && (tmr_count >= HRDY_CNT);
  assign lrdy = (tmr_count >= LRDY_CNT);
  // one counter restarts for either oscillator
  assign tmr_start = wake_start ||
                     (osc_next && !fast_osc_en_o);

  startup_timer #(
    .W (TMR_W)
  ) u_tmr (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .start_i (tmr_start),
    .count_o (tmr_count)
  );

  always @(posedge clock_i) begin
    if (rst_i) begin
      sysclk_sel_o <= {`OPM_FAST_RST, `OPM_DIV_RST};
    end else if (mode_fast || lrdy) begin
      sysclk_sel_o <= {fast_reg, div_reg};
    end
  end

  // ----------------------------------------------------------------------
  // wake sources
  // ----------------------------------------------------------------------
  assign halt_take = (state_reg == ST_RUN) && halt_i;
  assign port_wake = |(pa_prev_reg & ~porta_i & wake_en_reg);
  assign int_wake = |(int_req_i & armed_reg);
  assign int_svc = |(int_req_i & armed_reg & int_en_i) &&
                   !stack_full_i;
  assign wake_any = port_wake || int_wake || wdt_ovf_i;

  always @(posedge clock_i) begin
    if (rst_i) begin
      pa_prev_reg <= {PA_W{1'b0}};
      armed_reg   <= {INT_N{1'b0}};
    end else begin
      pa_prev_reg <= porta_i;
      if (halt_take) begin
        armed_reg <= ~int_req_i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    cause_next = cause_reg;
    resume_next = 1'b0;
    service_next = 1'b0;
    pcsp_next = 1'b0;
    wake_start = 1'b0;
    case (state_reg)
      ST_RUN: begin
        if (halt_i) begin
          if (!idle_on_halt_enable_reg) begin
            state_next = ST_SLEEP;
          end else if (sysidle_reg) begin
            state_next = ST_IDLE1;
          end else begin
            state_next = ST_IDLE0;
          end
        end
      end
      ST_SLEEP, ST_IDLE0, ST_IDLE1: begin
        if (wake_any) begin
          if (wdt_ovf_i) begin
            cause_next = WK_WDT;
          end else if (int_wake && int_svc) begin
            cause_next = WK_SVC;
          end else if (int_wake) begin
            cause_next = WK_RES;
          end else begin
            cause_next = WK_PORT;
          end
          state_next = ST_WAKE;
          wake_start = (state_reg != ST_IDLE1);
        end
      end
      ST_WAKE: begin
        // first instruction only once the selected source is stable
        if (sel_is_fast(sysclk_sel_o) ? hrdy : lrdy) begin
          state_next = ST_RUN;
          pcsp_next = (cause_reg == WK_WDT);
          service_next = (cause_reg == WK_SVC);
          resume_next = (cause_reg == WK_PORT) ||
                        (cause_reg == WK_RES);
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= ST_RUN;
      cause_reg <= WK_PORT;
    end else begin
      state_reg <= state_next;
      cause_reg <= cause_next;
    end
  end

  // ----------------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      pdf_reg <= 1'b0;
      tof_reg <= 1'b0;
    end else begin
      if (halt_take) begin
        pdf_reg <= 1'b1;
      end else if (clr_wdt_i) begin
        pdf_reg <= 1'b0;
      end
      if (wdt_ovf_i) begin
        tof_reg <= 1'b1;
      end else if (halt_take) begin
        tof_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (rst_i) begin
      fast_osc_en_o  <= 1'b0;
      fast_div_run_o <= 1'b0;
      sysclk_run_o   <= 1'b0;
      timebase_run_o <= 1'b0;
      low_clk_run_o  <= 1'b0;
      cpu_run_o      <= 1'b0;
      state_hold_o   <= 1'b0;
      wdt_clear_o    <= 1'b0;
      pc_sp_reset_o  <= 1'b0;
      int_service_o  <= 1'b0;
      wake_resume_o  <= 1'b0;
    end else begin
      fast_osc_en_o  <= osc_next;
      fast_div_run_o <= osc_next;
      sysclk_run_o   <= (state_next == ST_RUN) ||
                        (state_next == ST_IDLE1);
      timebase_run_o <= (state_next != ST_SLEEP) &&
                        (state_next != ST_WAKE);
      low_clk_run_o  <= 1'b1;
      cpu_run_o      <= (state_next == ST_RUN);
      state_hold_o   <= (state_next != ST_RUN);
      wdt_clear_o    <= halt_take || clr_wdt_i;
      pc_sp_reset_o  <= pcsp_next;
      int_service_o  <= service_next;
      wake_resume_o  <= resume_next;
    end
  end

  // ----------------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------------
  assign acc = psel_i && penable_i;
  assign wr_en = acc && pready_o && pwrite_i;

  always @(posedge clock_i) begin
    if (rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else begin
      pready_o  <= acc && !pready_o;
      pslverr_o <= acc && !pready_o &&
                   !(reg_hit(paddr_i, `OPM_MODE_OFS) ||
                     reg_hit(paddr_i, `OPM_CTRL_OFS) ||
                     reg_hit(paddr_i, `OPM_STAT_OFS) ||
                     reg_hit(paddr_i, `OPM_WAKE_OFS));
      prdata_o  <= 32'h00000000;
      if (acc && !pready_o && !pwrite_i) begin
        if (reg_hit(paddr_i, `OPM_MODE_OFS)) begin
          prdata_o[`OPM_DIV_MSB:`OPM_DIV_LSB] <= div_reg;
          prdata_o[`OPM_LRDY_BIT]  <= lrdy;
          prdata_o[`OPM_HRDY_BIT]  <= hrdy;
          prdata_o[`OPM_IDLE_ON_HALT_ENABLE_BIT] <= idle_on_halt_enable_reg;
          prdata_o[`OPM_FAST_BIT]  <= fast_reg;
        end else if (reg_hit(paddr_i, `OPM_CTRL_OFS)) begin
          prdata_o[`OPM_SYSIDLE_BIT] <= sysidle_reg;
        end else if (reg_hit(paddr_i, `OPM_STAT_OFS)) begin
          prdata_o[`OPM_PDF_BIT] <= pdf_reg;
          prdata_o[`OPM_TOF_BIT] <= tof_reg;
          prdata_o[`OPM_STATE_MSB:`OPM_STATE_LSB] <= state_reg;
        end else if (reg_hit(paddr_i, `OPM_WAKE_OFS)) begin
          prdata_o[PA_W-1:0] <= wake_en_reg;
        end
      end
    end
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      div_reg     <= `OPM_DIV_RST;
      fast_reg    <= `OPM_FAST_RST;
      idle_on_halt_enable_reg   <= `OPM_IDLE_ON_HALT_ENABLE_RST;
      sysidle_reg <= `OPM_SYSIDLE_RST;
      wake_en_reg <= {PA_W{1'b0}};
    end else if (wr_en) begin
      if (reg_hit(paddr_i, `OPM_MODE_OFS)) begin
        div_reg   <= pwdata_i[`OPM_DIV_MSB:`OPM_DIV_LSB];
        idle_on_halt_enable_reg <= pwdata_i[`OPM_IDLE_ON_HALT_ENABLE_BIT];
        fast_reg  <= pwdata_i[`OPM_FAST_BIT];
      end
      if (reg_hit(paddr_i, `OPM_CTRL_OFS)) begin
        sysidle_reg <= pwdata_i[`OPM_SYSIDLE_BIT];
      end
      if (reg_hit(paddr_i, `OPM_WAKE_OFS)) begin
        wake_en_reg <= pwdata_i[PA_W-1:0];
      end
    end
  end

endmodule

// file: core/opmode_defs.vh
/*
 * Register offsets, field positions, reset values and start-up counts
 * for the operating mode and power controller.
 * Assumes inclusion by bare name from files under core/.
 */
`ifndef OPMODE_DEFS_VH
`define OPMODE_DEFS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OPM_MODE_OFS      8'h00
`define OPM_CTRL_OFS      8'h04
`define OPM_STAT_OFS      8'h08
`define OPM_WAKE_OFS      8'h0c

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define OPM_FAST_BIT      0
`define OPM_IDLE_ON_HALT_ENABLE_BIT     1
`define OPM_HRDY_BIT      2
`define OPM_LRDY_BIT      3
`define OPM_DIV_LSB       5
`define OPM_DIV_MSB       7
`define OPM_SYSIDLE_BIT   7
`define OPM_PDF_BIT       0
`define OPM_TOF_BIT       1
`define OPM_STATE_LSB     4
`define OPM_STATE_MSB     6

// ----------------------------------------------------------------------
// reset values and fast divider threshold
// ----------------------------------------------------------------------
`define OPM_DIV_RST       3'h0
`define OPM_IDLE_ON_HALT_ENABLE_RST     1'b1
`define OPM_FAST_RST      1'b1
`define OPM_SYSIDLE_RST   1'b0
`define OPM_DIV_FAST_MIN  3'h2

// ----------------------------------------------------------------------
// start-up counts in clock_i cycles
// ----------------------------------------------------------------------
`define OPM_HRDY_CYC      5'h10
`define OPM_LRDY_CYC      5'h02

`endif

// file: core/startup_timer.v
/*
 * Shared oscillator start-up counter: restarts on a start pulse and
 * counts up, saturating at its top value.
 * Assumes a synchronous active-high reset standing for power-on.
 */
module startup_timer #(
  parameter W = 5
) (
  input  wire         clock_i,
  input  wire         rst_i,
  input  wire         start_i,
  output reg  [W-1:0] count_o
);

  // ----------------------------------------------------------------------
  // saturating counter
  // ----------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (rst_i || start_i) begin
      count_o <= {W{1'b0}};
    end else if (count_o != {W{1'b1}}) begin
      count_o <= count_o + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// file: dv/cpu_model.sv
/*
 * Partner model of the CPU: issues halt and clear-watchdog pulses.
 * Assumes run_i is the controller's cpu_run_o on the same clock.
 */
module cpu_model (
  input  wire  clock_i,
  input  wire  run_i,
  output logic halt_o,
  output logic clr_wdt_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    halt_o = 1'b0;
    clr_wdt_o = 1'b0;
  end

  // one-cycle instruction pulse, issued only while executing
  task exec(input logic h);
    @(posedge clock_i iff run_i);
    halt_o <= h;
    clr_wdt_o <= !h;
    @(posedge clock_i);
    halt_o <= 1'b0;
    clr_wdt_o <= 1'b0;
  endtask
endmodule

// file: dv/opmode_ctrl_monitor.sv
/*
 * Checker of port timing for opmode_ctrl.
 * Assumes it is bound into every opmode_ctrl instance.
 */
module opmode_ctrl_monitor (
  input wire       clock_i,
  input wire       rst_i,
  input wire       psel_i,
  input wire       penable_i,
  input wire       pready_o,
  input wire       halt_i,
  input wire       clr_wdt_i,
  input wire [3:0] sysclk_sel_o,
  input wire       fast_osc_en_o,
  input wire       fast_div_run_o,
  input wire       low_clk_run_o,
  input wire       cpu_run_o,
  input wire       state_hold_o,
  input wire       wdt_clear_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire        sel_slow = !sysclk_sel_o[3] && sysclk_sel_o[2:1] == 2'b00;
  logic [4:0] on_cnt;

  always @(posedge clock_i)
    if (rst_i || !fast_osc_en_o)
      on_cnt <= 5'h00;
    else if (on_cnt != 5'h1f)
      on_cnt <= on_cnt + 5'h01;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  sequence apb_acc;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence halt_take;
    cpu_run_o && halt_i;
  endsequence

  AST_APB_WAIT:
    assert property (apb_acc |=> pready_o ##1 !pready_o)
    else $error("apb ready not one wait state");
  AST_DIV_RUN:
    assert property (fast_div_run_o == fast_osc_en_o)
    else $error("dividers run without fast osc");
  AST_SLOW_STOP:
    assert property ($rose(sel_slow) |-> ##[0:2] !fast_osc_en_o)
    else $error("fast osc kept in slow mode");
  AST_HALT_ENTRY:
    assert property (halt_take |=> !cpu_run_o && state_hold_o
                     && wdt_clear_o ##1 !wdt_clear_o)
    else $error("halt entry wrong");
  AST_HOLD_HALTS:
    assert property (state_hold_o |-> !cpu_run_o)
    else $error("cpu runs while held");
  AST_LOW_CLK:
    assert property (!$past(rst_i) |-> low_clk_run_o)
    else $error("low clock stopped");
  AST_WAKE_FAST:
    assert property ($fell(state_hold_o) && !sel_slow |-> on_cnt >= 5'd15)
    else $error("fast wake before start-up");
  AST_CLR_WDT:
    assert property (clr_wdt_i |=> wdt_clear_o)
    else $error("clear watchdog not passed on");
endmodule

bind opmode_ctrl opmode_ctrl_monitor u_mon (.clock_i, .rst_i, .psel_i,
  .penable_i, .pready_o, .halt_i, .clr_wdt_i, .sysclk_sel_o,
  .fast_osc_en_o, .fast_div_run_o, .low_clk_run_o, .cpu_run_o,
  .state_hold_o, .wdt_clear_o);

// file: dv/tb_operating_mode_power_controller.sv
/*
 * Bench for opmode_ctrl: registers, clock mode table, halt and wake.
 * Assumes cpu_model as partner and the bound monitor.
 */
module tb_operating_mode_power_controller;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 1'b0, rst_i = 1'b1, e, fo;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, porta = 8'hff;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, halt, clr_wdt, wdt_ovf = 1'b0;
  logic [3:0]  int_req = 4'h0, int_en = 4'h6, sel;
  logic        stack_full = 1'b0, fosc, fdiv, sys_run, tb_run, low_run;
  logic        cpu_run, hold, wdt_clr, pcsp, isvc, resume;
  int          mismatches = 0, check_count = 0, cycles = 0, n, i;
  logic [11:0] rows [10] = '{12'h018, 12'h020, 12'h221, 12'h422,
    12'h623, 12'h824, 12'ha25, 12'hc26, 12'he27, 12'he3f};
  wire  [2:0]  wk = {isvc, pcsp, resume};
  wire  [5:0]  cs = {cpu_run, sys_run, tb_run, fosc, low_run, hold};

  always #2 clock_i = ~clock_i;

  opmode_ctrl i_dut (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .halt_i(halt), .clr_wdt_i(clr_wdt),
    .wdt_ovf_i(wdt_ovf), .porta_i(porta), .int_req_i(int_req),
    .int_en_i(int_en), .stack_full_i(stack_full), .sysclk_sel_o(sel),
    .fast_osc_en_o(fosc), .fast_div_run_o(fdiv), .sysclk_run_o(sys_run),
    .timebase_run_o(tb_run), .low_clk_run_o(low_run),
    .cpu_run_o(cpu_run), .state_hold_o(hold), .wdt_clear_o(wdt_clr),
    .pc_sp_reset_o(pcsp), .int_service_o(isvc), .wake_resume_o(resume));

  cpu_model i_cpu (.clock_i(clock_i), .run_i(cpu_run), .halt_o(halt),
    .clr_wdt_o(clr_wdt));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask

  task wake(input logic [2:0] exp);
    n = 0;
    while (wk === 3'b000 && n < 100) begin
      @(negedge clock_i);
      n++;
    end
    chk(wk, exp);
    @(posedge clock_i);
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      wrap_up;
    end
  end

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clock_i);
    @(negedge clock_i);
    chk({sel, cs}, {4'h8, 6'h00});
    @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (20) @(posedge clock_i);
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0f);
    for (i = 1; i < 5; i++) begin
      apb(1'b0, 8'h04 * i[7:0], 32'h0);
      chk(q, 32'h0);
      chk(e, i == 4);
    end
    $display("test reset done");
    for (i = 0; i < 10; i++) begin
      apb(1'b1, 8'h00, {24'h0, rows[i][11:4]});
      repeat (20) @(posedge clock_i);
      fo = rows[i][3] || rows[i][2:1] != 2'b00;
      chk(sel, rows[i][3:0]);
      chk({fosc, fdiv}, {fo, fo});
      apb(1'b0, 8'h00, 32'h0);
      chk(q, {rows[i][11:9], 2'b01, fo, rows[i][5:4]});
    end
    $display("test modes done");
    apb(1'b1, 8'h00, 32'h01);
    apb(1'b1, 8'h0c, 32'h01);
    i_cpu.exec(1'b1);
    @(negedge clock_i);
    chk(cs, 6'b000011);
    apb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h11);
    porta <= 8'hfe;
    wake(3'b001);
    chk(n >= 16, 1'b1);
    chk({sel, cpu_run}, {4'h8, 1'b1});
    apb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h01);
    i_cpu.exec(1'b0);
    apb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h00);
    $display("test sleep done");
    porta <= 8'hff;
    int_req <= 4'h2;
    apb(1'b1, 8'h00, 32'h03);
    i_cpu.exec(1'b1);
    @(negedge clock_i);
    chk(cs, 6'b001011);
    repeat (10) @(posedge clock_i);
    chk(cpu_run, 1'b0);
    int_req <= 4'h6;
    wake(3'b100);
    int_req <= 4'h0;
    stack_full <= 1'b1;
    apb(1'b1, 8'h04, 32'h80);
    i_cpu.exec(1'b1);
    @(negedge clock_i);
    chk(cs, 6'b011111);
    int_req <= 4'h2;
    wake(3'b001);
    int_req <= 4'h0;
    stack_full <= 1'b0;
    int_en <= 4'h0;
    i_cpu.exec(1'b1);
    int_req <= 4'h2;
    wake(3'b001);
    int_req <= 4'h0;
    int_en <= 4'h6;
    i_cpu.exec(1'b1);
    wdt_ovf <= 1'b1;
    @(posedge clock_i);
    wdt_ovf <= 1'b0;
    wake(3'b010);
    apb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h03);
    i_cpu.exec(1'b1);
    apb(1'b0, 8'h08, 32'h0);
    chk(q, 32'h31);
    porta <= 8'hfe;
    wake(3'b001);
    $display("test idle done");
    wrap_up;
  end
endmodule
